// ===== hw/aibr_defines.vh
// Register offsets, field positions, reset values and codes for the mux and bias register bank.
`ifndef AIBR_DEFINES_VH
`define AIBR_DEFINES_VH

// Register offsets on the local register port.
`define AIBR_ADDR_INPUT_MUX_CONTROL_FIRST 4'h0
`define AIBR_ADDR_BIAS 4'h1
`define AIBR_ADDR_INPUT_MUX_CONTROL_SECOND 4'h2
`define AIBR_ADDR_SYSTEM_CONTROL_FIRST 4'h3

// Reset values.
`define AIBR_RST_INPUT_MUX_CONTROL_FIRST 8'h01
`define AIBR_RST_BIAS 8'h00
`define AIBR_RST_INPUT_MUX_CONTROL_SECOND 7'h00
`define AIBR_RST_SYSTEM_CONTROL_FIRST 7'h00

// Second mux control register fields.
`define AIBR_CLKSRC_BIT 7
`define AIBR_IREF_HI 6
`define AIBR_IREF_LO 5
`define AIBR_RSEL_HI 4
`define AIBR_RSEL_LO 3
`define AIBR_MON_HI 2
`define AIBR_MON_LO 0

// First mux control register fields.
`define AIBR_PSEL_HI 5
`define AIBR_PSEL_LO 3
`define AIBR_NSEL_HI 2
`define AIBR_NSEL_LO 0

// System control gain field.
`define AIBR_GAIN_HI 6
`define AIBR_GAIN_LO 4
`define AIBR_GAIN_UNITY 3'h0

// Internal reference control codes.
`define AIBR_IREF_OFF 2'h0
`define AIBR_IREF_ON 2'h1

// Reference select codes.
`define AIBR_RSEL_PAIR0 2'h0
`define AIBR_RSEL_PAIR1 2'h1
`define AIBR_RSEL_INT 2'h2
`define AIBR_RSEL_INT_OUT 2'h3

// Monitor select codes.
`define AIBR_MON_NORMAL 3'h0
`define AIBR_MON_OFFSET 3'h1
`define AIBR_MON_GAIN 3'h2
`define AIBR_MON_TEMP 3'h3
`define AIBR_MON_REF1 3'h4
`define AIBR_MON_REF0 3'h5
`define AIBR_MON_AVDD 3'h6
`define AIBR_MON_DVDD 3'h7

// Converter input source codes driven to the analog front end.
`define AIBR_SRC_CHANNELS 3'h0
`define AIBR_SRC_MIDSUPPLY 3'h1
`define AIBR_SRC_REFERENCE 3'h2
`define AIBR_SRC_TEMP 3'h3
`define AIBR_SRC_REF1_QTR 3'h4
`define AIBR_SRC_REF0_QTR 3'h5
`define AIBR_SRC_AVDD_QTR 3'h6
`define AIBR_SRC_DVDD_QTR 3'h7

`define AIBR_ZERO8 8'h00

// Number of outside levels that pass a synchroniser.
`define AIBR_SYNC_N 4

`endif

// ===== hw/aibr_sync2.v
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module aibr_sync2 (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Level in and out.
   input wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg sync_q;

   // The first stage is read only by the second stage.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// ===== hw/aibr_regs.v
// Mux, bias, reference and system monitor control registers with monitor override logic.
//
// Summary of operation
// - Each bit of the bias register enables mid-supply bias on its analog input; all reset to 0.
// - Bit 7 of the second mux register reads 0 for internal oscillator and 1 for external clock.
// - Reference control 00 keeps the internal reference off (default) and 01 keeps it on.
// - Reference control 10/11 powers the reference during conversion; sleep or start low drop it.
// - Reference select 00 pair 0, 01 pair 1, 10 internal, 11 internal also driven onto pair 0.
// - Any non-normal monitor select overrides channel and bias selections; only 100 and 101 override reference select.
// - Monitor 000 is normal (default); 001 ties both converter inputs to mid-supply.
// - Monitor 010 applies the selected reference; 011 applies the temperature diode.
// - Monitors 100..111 apply a quarter of ref pair 1, ref pair 0, analog and digital supply.
// - Monitors 010..111 force gain 1; 000 and 001 use the stored gain.
// - Leaving the forcing monitors restores the stored gain, which is never overwritten.
// - After reset reference control, reference select and monitor read 0; clock flag is live.
// - Stored gain is bits 6..4 of system control, codes 0..7 for gains 1 to 128.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "aibr_defines.vh"
module aibr_regs #(
   parameter ADDR_W = 4,
   parameter CHAN_N = 8
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Register port.
   input wire [ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Device status inputs.
   input wire ext_clk_in_use,
   input wire conversion_active,
   input wire sleep_cmd,
   input wire start_pin,
   // Analog front end controls.
   output reg [CHAN_N-1:0] input_bias_enable,
   output reg [2:0] positive_channel_select,
   output reg [2:0] negative_channel_select,
   output reg [2:0] converter_input_source,
   output reg [1:0] reference_route,
   output reg ref_int_drive_pair_zero,
   output reg internal_ref_power,
   output reg [2:0] gain_amplifier,
   output reg monitor_override
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Outside levels that each pass their own synchroniser: clock flag, start,
   // conversion and sleep.
   localparam SYNC_N = `AIBR_SYNC_N;
   // Reset image of the first mux register; the channel select outputs reset to its
   // fields so that the pins and the register agree from the first edge.
   localparam [7:0] INPUT_MUX_CONTROL_FIRST_RST = `AIBR_RST_INPUT_MUX_CONTROL_FIRST;
   reg [7:0] input_mux_control_first_q;
   reg [CHAN_N-1:0] bias_q;
   reg [6:0] input_mux_control_second_q;
   reg [6:0] system_control_first_q;
   reg ref_follow_q;
   reg [7:0] rdata_d;
   wire ext_clk_s;
   wire start_s;
   wire conv_s;
   wire sleep_s;
   wire [2:0] mon;
   wire [1:0] iref;
   wire [1:0] rsel;
   wire [SYNC_N-1:0] lvl_async;
   wire [SYNC_N-1:0] lvl_sync;
   genvar g;

   // Returns true for monitor codes that force unity gain.
   function gain_forced;
      input [2:0] code;
      begin
         gain_forced = (code != `AIBR_MON_NORMAL) && (code != `AIBR_MON_OFFSET);
      end
   endfunction

   // Returns true for any monitor code other than normal operation.
   // Used by both the override flag and the bias gate so they never disagree.
   function mon_active;
      input [2:0] code;
      begin
         mon_active = (code != `AIBR_MON_NORMAL);
      end
   endfunction

   // Returns true for the two quarter-reference monitors.
   // These take the reference path away from the reference select field.
   function ref_monitor;
      input [2:0] code;
      begin
         ref_monitor = (code == `AIBR_MON_REF0) || (code == `AIBR_MON_REF1);
      end
   endfunction

   // Pins and outside levels pass two flops before use, one synchroniser per level.
   // Only the second flop of each pair is read, so a metastable first stage never
   // reaches the register or follow logic.
   assign lvl_async = {sleep_cmd, conversion_active, start_pin, ext_clk_in_use};
   generate
      for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
         aibr_sync2 u_aibr_sync2 (
            .clk(clk),
            .rst_b(rst_b),
            .async_in(lvl_async[g]),
            .sync_out(lvl_sync[g])
         );
      end
   endgenerate

   // Unpack in the order the levels were packed above.
   assign ext_clk_s = lvl_sync[0];
   assign start_s = lvl_sync[1];
   assign conv_s = lvl_sync[2];
   assign sleep_s = lvl_sync[3];

   assign mon = input_mux_control_second_q[`AIBR_MON_HI:`AIBR_MON_LO];
   assign iref = input_mux_control_second_q[`AIBR_IREF_HI:`AIBR_IREF_LO];
   assign rsel = input_mux_control_second_q[`AIBR_RSEL_HI:`AIBR_RSEL_LO];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Software writes; gain is stored separately so monitor forcing never loses it.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         input_mux_control_first_q <= `AIBR_RST_INPUT_MUX_CONTROL_FIRST;
         bias_q <= {CHAN_N{1'b0}};
         input_mux_control_second_q <= `AIBR_RST_INPUT_MUX_CONTROL_SECOND;
         system_control_first_q <= `AIBR_RST_SYSTEM_CONTROL_FIRST;
      end else if (reg_wr) begin
         case (reg_addr)
            `AIBR_ADDR_INPUT_MUX_CONTROL_FIRST: begin
               input_mux_control_first_q <= reg_wdata;
            end
            `AIBR_ADDR_BIAS: begin
               bias_q <= reg_wdata[CHAN_N-1:0];
            end
            `AIBR_ADDR_INPUT_MUX_CONTROL_SECOND: begin
               input_mux_control_second_q <= reg_wdata[6:0];
            end
            `AIBR_ADDR_SYSTEM_CONTROL_FIRST: begin
               system_control_first_q <= reg_wdata[6:0];
            end
            default: begin
               input_mux_control_first_q <= input_mux_control_first_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Reference power follow state
   // ----------------------------------------------------------------
   // In follow mode the reference comes up with a conversion and drops on sleep or start low.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_follow_q <= 1'b0;
      end else if (sleep_s || !start_s) begin
         ref_follow_q <= 1'b0;
      end else if (conv_s) begin
         ref_follow_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Read mux; the clock flag is the live synchronised status, unmapped reads give zero.
   always @* begin
      rdata_d = `AIBR_ZERO8;
      if (reg_rd) begin
         case (reg_addr)
            `AIBR_ADDR_INPUT_MUX_CONTROL_FIRST: begin
               rdata_d = input_mux_control_first_q;
            end
            `AIBR_ADDR_BIAS: begin
               rdata_d = bias_q;
            end
            `AIBR_ADDR_INPUT_MUX_CONTROL_SECOND: begin
               rdata_d = {ext_clk_s, input_mux_control_second_q};
            end
            `AIBR_ADDR_SYSTEM_CONTROL_FIRST: begin
               rdata_d = {1'b0, system_control_first_q};
            end
            default: begin
               rdata_d = `AIBR_ZERO8;
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `AIBR_ZERO8;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Front end controls with monitor override
   // ----------------------------------------------------------------
   // Every front end output is a flop, so a register write reaches the analog side
   // one edge after the register takes it. Each group has its own process so that
   // an output's reset value and override can be read off in one place.

   // Channel selects are registered copies of the first mux register. While a monitor
   // is active the analog side takes its inputs from converter_input_source instead.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         positive_channel_select <= INPUT_MUX_CONTROL_FIRST_RST[`AIBR_PSEL_HI:`AIBR_PSEL_LO];
         negative_channel_select <= INPUT_MUX_CONTROL_FIRST_RST[`AIBR_NSEL_HI:`AIBR_NSEL_LO];
      end else begin
         positive_channel_select <= input_mux_control_first_q[`AIBR_PSEL_HI:`AIBR_PSEL_LO];
         negative_channel_select <= input_mux_control_first_q[`AIBR_NSEL_HI:`AIBR_NSEL_LO];
      end
   end

   // Override flag and bias enables. The bias stays off under any monitor code so an
   // offset or supply measurement is never pulled by an input bias.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         monitor_override <= 1'b0;
         input_bias_enable <= {CHAN_N{1'b0}};
      end else begin
         monitor_override <= mon_active(mon);
         if (mon_active(mon)) begin
            input_bias_enable <= {CHAN_N{1'b0}};
         end else begin
            input_bias_enable <= bias_q;
         end
      end
   end

   // Converter input source follows the monitor code one for one; normal operation
   // hands the inputs back to the channel selects.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         converter_input_source <= `AIBR_SRC_CHANNELS;
      end else begin
         case (mon)
            `AIBR_MON_NORMAL: converter_input_source <= `AIBR_SRC_CHANNELS;
            `AIBR_MON_OFFSET: converter_input_source <= `AIBR_SRC_MIDSUPPLY;
            `AIBR_MON_GAIN: converter_input_source <= `AIBR_SRC_REFERENCE;
            `AIBR_MON_TEMP: converter_input_source <= `AIBR_SRC_TEMP;
            `AIBR_MON_REF1: converter_input_source <= `AIBR_SRC_REF1_QTR;
            `AIBR_MON_REF0: converter_input_source <= `AIBR_SRC_REF0_QTR;
            `AIBR_MON_AVDD: converter_input_source <= `AIBR_SRC_AVDD_QTR;
            default: converter_input_source <= `AIBR_SRC_DVDD_QTR;
         endcase
      end
   end

   // Reference routing. The quarter-reference monitors take over the reference path
   // and keep the internal reference off the pair 0 pins while those are measured.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reference_route <= `AIBR_RSEL_PAIR0;
         ref_int_drive_pair_zero <= 1'b0;
      end else begin
         case (mon)
            `AIBR_MON_REF1: reference_route <= `AIBR_RSEL_PAIR1;
            `AIBR_MON_REF0: reference_route <= `AIBR_RSEL_PAIR0;
            default: reference_route <= rsel;
         endcase
         ref_int_drive_pair_zero <= (rsel == `AIBR_RSEL_INT_OUT) && !ref_monitor(mon);
      end
   end

   // Reference power from the control field. The follow codes take the state kept by
   // the follow process, so the reference comes up with a conversion and stays on until sleep or start low.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         internal_ref_power <= 1'b0;
      end else begin
         case (iref)
            `AIBR_IREF_OFF: internal_ref_power <= 1'b0;
            `AIBR_IREF_ON: internal_ref_power <= 1'b1;
            default: internal_ref_power <= ref_follow_q;
         endcase
      end
   end

   // Gain is forced to unity for the forcing monitors. The stored code in system_control_first_q is
   // never touched here, so leaving a forcing monitor brings the user's gain back.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gain_amplifier <= `AIBR_GAIN_UNITY;
      end else if (gain_forced(mon)) begin
         gain_amplifier <= `AIBR_GAIN_UNITY;
      end else begin
         gain_amplifier <= system_control_first_q[`AIBR_GAIN_HI:`AIBR_GAIN_LO];
      end
   end
endmodule

// ===== testbench/aibr_regs_properties.sv
// Checker for the mux, bias and reference register bank outputs.
`timescale 1ns/1ps
module aibr_regs_chk #(
   parameter ADDR_W = 4,
   parameter CHAN_N = 8
) (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Register port.
   input wire [ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Device status.
   input wire ext_clk_in_use,
   input wire conversion_active,
   input wire sleep_cmd,
   input wire start_pin,
   // Front end controls.
   input wire [CHAN_N-1:0] input_bias_enable,
   input wire [2:0] positive_channel_select,
   input wire [2:0] negative_channel_select,
   input wire [2:0] converter_input_source,
   input wire [1:0] reference_route,
   input wire ref_int_drive_pair_zero,
   input wire internal_ref_power,
   input wire [2:0] gain_amplifier,
   input wire monitor_override
);
   // All checks share the core clock and its reset.
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_BIAS_OVR:
      assert property (monitor_override |-> input_bias_enable == '0) else $error("bias under monitor");
   AST_BIAS_WR:
      assert property ((reg_wr && reg_addr == 1) ##2 !monitor_override
         |-> input_bias_enable == $past(reg_wdata, 2)) else $error("bias not written");
   AST_MON_SRC:
      assert property (reg_wr && reg_addr == 2 |-> ##2 converter_input_source ==
         $past(reg_wdata[2:0], 2) && monitor_override == ($past(reg_wdata[2:0], 2) != 0))
         else $error("monitor source wrong");
   AST_GAIN_FORCE:
      assert property (converter_input_source >= 3'h2 |-> gain_amplifier == 3'h0)
         else $error("gain not forced");
   AST_GAIN_KEEP:
      assert property ((reg_wr && reg_addr == 3) ##2 converter_input_source < 3'h2
         |-> gain_amplifier == $past(reg_wdata[6:4], 2)) else $error("stored gain lost");
   AST_ROUTE:
      assert property (reg_wr && reg_addr == 2 && reg_wdata[2:1] != 2'b10 |-> ##2
         reference_route == $past(reg_wdata[4:3], 2) &&
         ref_int_drive_pair_zero == ($past(reg_wdata[4:3], 2) == 2'b11)) else $error("route wrong");
   AST_REFMON:
      assert property (reg_wr && reg_addr == 2 && reg_wdata[2:1] == 2'b10 |-> ##2
         reference_route == {1'b0, !$past(reg_wdata[0], 2)} && !ref_int_drive_pair_zero)
         else $error("ref monitor route wrong");
   AST_IREF:
      assert property (reg_wr && reg_addr == 2 && !reg_wdata[6] |-> ##2
         internal_ref_power == $past(reg_wdata[5], 2)) else $error("ref power wrong");
   AST_CLKFLAG:
      assert property (reg_rd && reg_addr == 2 |=> reg_rdata[7] == $past(ext_clk_in_use, 3))
         else $error("clock flag wrong");
endmodule
bind aibr_regs aibr_regs_chk #(.ADDR_W(ADDR_W), .CHAN_N(CHAN_N)) u_aibr_regs_chk (.*);

// ===== testbench/aibr_host.sv
// Host controller model driving the register port of the mux and bias bank.
`timescale 1ns/1ps
module aibr_host (
   // Clock.
   input wire clk,
   // Register port.
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire [7:0] reg_rdata
);
   // The bus is idle from time zero.
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write; a fresh edge starts the next access so no strobe is set twice.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle read; the data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   // Monitor write that powers the reference first when a reference pair is watched.
   task automatic monitor(input logic [7:0] d);
      if (d[2:1] == 2'b10) begin
         wr(4'h2, {3'b001, d[4:3], 3'b000});
      end
      wr(4'h2, d);
   endtask
endmodule

// ===== testbench/aibr_regs_tb.sv
// Self-checking testbench for the mux, bias and reference register bank.
`timescale 1ns/1ps
module aibr_regs_tb;
   logic clk;
   logic rst_b;
   logic ext_clk_in_use;
   logic conversion_active;
   logic sleep_cmd;
   logic start_pin;
   wire [3:0] reg_addr;
   wire [7:0] reg_wdata;
   wire reg_wr;
   wire reg_rd;
   wire [7:0] reg_rdata;
   wire [7:0] input_bias_enable;
   wire [2:0] positive_channel_select;
   wire [2:0] negative_channel_select;
   wire [2:0] converter_input_source;
   wire [1:0] reference_route;
   wire ref_int_drive_pair_zero;
   wire internal_ref_power;
   wire [2:0] gain_amplifier;
   wire monitor_override;
   logic [7:0] rdata_seen;
   logic [7:0] m;
   int miscompares = 0;
   int n_compared = 0;
   aibr_regs u_aibr_regs (.*);
   aibr_host u_aibr_host (.*);
   // 200 MHz core clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Compares one value and counts the outcome.
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Reads a register and compares it.
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      u_aibr_host.rd(a, rdata_seen);
      chk("rdata", rdata_seen, exp);
   endtask
   // Waits until a register write has reached the outputs.
   task automatic settle;
      repeat (2) @(negedge clk);
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #20000;
      miscompares++;
      print_verdict();
   end
   // Test sequence.
   initial begin
      rst_b = 1'b0;
      ext_clk_in_use = 1'b1;
      conversion_active = 1'b0;
      sleep_cmd = 1'b0;
      start_pin = 1'b1;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(4'h2, 8'h80);
      rchk(4'h1, 8'h00);
      rchk(4'h0, 8'h01);
      chk("psel", 8'(positive_channel_select), 8'h00);
      chk("nsel", 8'(negative_channel_select), 8'h01);
      $display("test reset done");
      u_aibr_host.wr(4'h1, 8'hA5);
      settle();
      chk("bias", input_bias_enable, 8'hA5);
      u_aibr_host.wr(4'h0, 8'h2B);
      settle();
      chk("psel", 8'(positive_channel_select), 8'h05);
      chk("nsel", 8'(negative_channel_select), 8'h03);
      u_aibr_host.wr(4'h2, 8'h00);
      rchk(4'h2, 8'h80);
      @(posedge clk);
      ext_clk_in_use <= 1'b0;
      // The flag needs two synchroniser flops before a read can see it.
      @(posedge clk);
      rchk(4'h2, 8'h00);
      u_aibr_host.wr(4'h2, 8'hFF);
      rchk(4'h2, 8'h7F);
      $display("test flag done");
      for (int r = 0; r < 4; r++) begin
         u_aibr_host.wr(4'h2, 8'(r << 3));
         settle();
         chk("route", 8'(reference_route), 8'(r));
         chk("pair0", 8'(ref_int_drive_pair_zero), 8'(r == 3));
         chk("power", 8'(internal_ref_power), 8'h00);
      end
      u_aibr_host.wr(4'h3, 8'hD0);
      rchk(4'h3, 8'h50);
      for (int i = 0; i < 9; i++) begin
         m = 8'(i % 8);
         u_aibr_host.monitor(8'h38 | m);
         settle();
         chk("source", 8'(converter_input_source), m);
         chk("gain", 8'(gain_amplifier), (m < 2) ? 8'h05 : 8'h00);
         chk("bias", input_bias_enable, (m == 0) ? 8'hA5 : 8'h00);
         chk("route", 8'(reference_route), (m == 4) ? 8'h01 : (m == 5) ? 8'h00 : 8'h03);
         chk("power", 8'(internal_ref_power), 8'h01);
         chk("override", 8'(monitor_override), 8'(m != 0));
         chk("pair0", 8'(ref_int_drive_pair_zero), 8'(m != 4 && m != 5));
      end
      $display("test monitor done");
      u_aibr_host.wr(4'h2, 8'h40);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         conversion_active <= 1'b1;
         sleep_cmd <= (k == 1);
         start_pin <= (k != 3);
         repeat (5) @(posedge clk);
         @(negedge clk);
         chk("follow", 8'(internal_ref_power), 8'(k % 2 == 0));
      end
      $display("test follow done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(negedge clk);
      chk("rst bias", input_bias_enable, 8'h00);
      chk("rst gain", 8'(gain_amplifier), 8'h00);
      chk("rst nsel", 8'(negative_channel_select), 8'h01);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(4'h2, 8'h00);
      rchk(4'h3, 8'h00);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule
